/* cws_defs.svh */
`ifndef CWS_DEFS_SVH
`define CWS_DEFS_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CWS_CLK_HZ        20000000
`define CWS_LINE_LOSS_MS  40
`define CWS_LINE_LOSS_CYC ((`CWS_LINE_LOSS_MS * 20000) / 1)
`define CWS_ACK_DLY_NS    1600
`define CWS_ACK_DLY_CYC   ((`CWS_ACK_DLY_NS + 49) / 50)
`define CWS_TIMEOUT_CYC   200
`define CWS_SETTLE_PULSES 8
// ---------------------------------------------------------------
// status word field positions
// ---------------------------------------------------------------
`define CWS_ST_INT_ACK_STATUS       0
`define CWS_ST_M1         5
`define CWS_A15           15
// ---------------------------------------------------------------
// vector layout: module data line bits 1..3 carry module id
// ---------------------------------------------------------------
`define CWS_VEC_BASE      8'hC7
`endif

/* cws_pkg.sv */
package cws_pkg;
  // wait state machine
  typedef enum logic [1:0] {
    CWS_RUN     = 2'b00,
    CWS_WAITING = 2'b01
  } cws_wait_t;
  // interrupt source in service
  typedef enum logic [2:0] {
    CWS_SRC_NONE = 3'b000,
    CWS_SRC_TMO  = 3'b001,
    CWS_SRC_MOD  = 3'b010,
    CWS_SRC_MARK = 3'b011
  } cws_src_t;
  // pending interrupt bits
  typedef struct packed {
    logic       timeout;
    logic [2:0] modules;
    logic       mark;
  } cws_irq_t;
endpackage

/* cws_delay.sv */
`timescale 1ns/1ps
`include "cws_defs.svh"
// ---------------------------------------------------------------
// level delay line: output follows a rising input after a fixed count
// ---------------------------------------------------------------
module cws_delay #(
  parameter int CYC = `CWS_ACK_DLY_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in, delayed level out
  input  wire logic din,
  output logic      dout
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       dout_q;
  logic       dout_d;
  // a low input clears at once; only the rise is delayed
  always_comb
  begin
    cnt_d  = cnt_q;
    dout_d = dout_q;
    if (!din)
    begin
      cnt_d  = 8'h00;
      dout_d = 1'b0;
    end
    else if (cnt_q < 8'(CYC))
      cnt_d = cnt_q + 8'h01;
    else
      dout_d = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q  <= 8'h00;
      dout_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      dout_q <= dout_d;
    end
  end
  assign dout = dout_q;
endmodule

/* cws_top.sv */
`timescale 1ns/1ps
`include "cws_defs.svh"
module cws_top #(
  parameter int LOSS_CYC    = `CWS_LINE_LOSS_CYC,
  parameter int TIMEOUT_CYC = `CWS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // line pulses and line-mark clock (pins)
  input  wire logic       line_pulse,
  input  wire logic       line_times_eight,
  // processor side
  input  wire logic       status_strobe,
  input  wire logic       addr15,
  input  wire logic [7:0] data_in,
  input  wire logic       mark_en_wr,
  input  wire logic       mark_en_val,
  input  wire logic       int_clear,
  output logic            processor_go,
  output logic            processor_irq,
  output logic            system_reset,
  output logic [7:0]      vector_out,
  output logic            vector_oe,
  output logic [7:0]      status_word,
  // module bus side (pins)
  input  wire logic       module_ack,
  input  wire logic [2:0] module_irq,
  input  wire logic [2:0] module_data_lines,
  output logic            vector_request,
  output logic            module_cycle_flag,
  output logic            delayed_response,
  output logic            response_timeout_irq,
  output logic            line_mark_irq
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [9:0] s1_q;
  logic [9:0] s2_q;
  logic [9:0] s3_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
      s3_q <= 10'h000;
    end
    else
    begin
      s1_q <= {module_data_lines, line_pulse, line_times_eight,
               status_strobe, module_ack, module_irq};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic line_rise;
  logic x8_rise;
  logic stb_rise;
  logic ack_s;
  logic [2:0] mirq_s;
  logic [2:0] mdl_s;
  assign mdl_s     = s2_q[9:7];
  assign line_rise = s2_q[6] & ~s3_q[6];
  assign x8_rise   = s2_q[5] & ~s3_q[5];
  assign stb_rise  = s2_q[4] & ~s3_q[4];
  assign ack_s     = s2_q[3];
  assign mirq_s    = s2_q[2:0];
  // -------------------------------------------------------------
  // reset generator
  // -------------------------------------------------------------
  logic [23:0] loss_q;
  logic [23:0] loss_d;
  logic [3:0]  settle_q;
  logic [3:0]  settle_d;
  logic        sysrst_q;
  logic        sysrst_d;
  // missing pulses hold the counter in reset; eight pulses release
  always_comb
  begin
    loss_d   = line_rise ? 24'h00_0000 : loss_q + 24'h00_0001;
    settle_d = settle_q;
    if (loss_q >= 24'(LOSS_CYC) && !line_rise)  // a fresh pulse restarts the count
    begin
      loss_d   = loss_q;
      settle_d = 4'h0;
    end
    else if (line_rise && settle_q < 4'(`CWS_SETTLE_PULSES))
      settle_d = settle_q + 4'h1;
    sysrst_d = (settle_d < 4'(`CWS_SETTLE_PULSES));
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loss_q   <= 24'h00_0000;
      settle_q <= 4'h0;
      sysrst_q <= 1'b1;
    end
    else
    begin
      loss_q   <= loss_d;
      settle_q <= settle_d;
      sysrst_q <= sysrst_d;
    end
  end
  logic irst;
  assign irst = rst | sysrst_q;
  // -------------------------------------------------------------
  // status latch, wait logic, timeout, interrupts
  // -------------------------------------------------------------
  logic [7:0]             st_q, st_d;
  logic [2:0]             mreg_q, mreg_d;
  cws_pkg::cws_wait_t     wst_q, wst_d;
  logic                   go_q, go_d;
  logic [15:0]            tmo_q, tmo_d;
  logic                   tmo_run_q, tmo_run_d;
  cws_pkg::cws_irq_t      pend_q, pend_d;
  logic                   mark_en_q, mark_en_d;
  cws_pkg::cws_src_t      srv_q, srv_d;
  logic                   vreq_q, vreq_d;
  logic                   mcyc_q, mcyc_d;
  logic                   mark_ack_q, mark_ack_d;
  logic [7:0]             vec_q, vec_d;
  logic                   voe_q, voe_d;
  logic                   irq_q, irq_d;
  logic                   dly_ack;
  logic                   dresp;
  cws_delay #(.CYC(`CWS_ACK_DLY_CYC)) u_dly (
    .clk  (clk),
    .rst  (irst),
    .din  (ack_s),
    .dout (dly_ack)
  );
  assign dresp = dly_ack | mark_ack_q;
  // main next-state logic
  always_comb
  begin
    st_d       = st_q;
    mreg_d     = mreg_q;
    wst_d      = wst_q;
    tmo_d      = tmo_q;
    tmo_run_d  = tmo_run_q;
    pend_d     = pend_q;
    srv_d      = srv_q;
    vreq_d     = vreq_q;
    mcyc_d     = mcyc_q;
    mark_ack_d = 1'b0;
    vec_d      = vec_q;
    voe_d      = voe_q;
    mark_en_d  = mark_en_wr ? mark_en_val : mark_en_q;
    if (stb_rise)
    begin
      st_d   = data_in;
      mreg_d = mirq_s;
      mcyc_d = addr15;
      vreq_d = 1'b0;
      voe_d  = 1'b0;
      if (addr15 || data_in[`CWS_ST_INT_ACK_STATUS])
        wst_d = cws_pkg::CWS_WAITING;
      if (addr15)
      begin
        tmo_d     = 16'h0000;
        tmo_run_d = 1'b1;
      end
      if (data_in[`CWS_ST_INT_ACK_STATUS])
      begin
        // internal or spurious sources answer themselves, else the wait never ends
        mark_ack_d = 1'b1;
        if (pend_q.timeout)
          srv_d = cws_pkg::CWS_SRC_TMO;
        else if (|pend_q.modules)
        begin
          srv_d      = cws_pkg::CWS_SRC_MOD;
          vreq_d     = 1'b1;
          mark_ack_d = 1'b0;  // the module answers this one
        end
        else if (pend_q.mark)
        begin
          srv_d      = cws_pkg::CWS_SRC_MARK;
          mark_ack_d = 1'b1;
        end
        else
          srv_d = cws_pkg::CWS_SRC_NONE;
        // vector placed instead of the instruction
        vec_d = `CWS_VEC_BASE;
        voe_d = 1'b1;
      end
    end
    if (srv_q == cws_pkg::CWS_SRC_MOD && ack_s)
      vec_d = {4'hC, mdl_s, 1'b1};
    // clear ahead of the sources so a same-cycle set wins
    if (int_clear)
    begin
      pend_d.timeout = 1'b0;
      pend_d.mark    = 1'b0;
    end
    if (tmo_run_q && !stb_rise)
    begin
      if (dresp)
        tmo_run_d = 1'b0;
      else if (tmo_q >= 16'(TIMEOUT_CYC - 1))
      begin
        tmo_run_d = 1'b0;
        pend_d.timeout = 1'b1;
      end
      else
        tmo_d = tmo_q + 16'h0001;
    end
    if (wst_q == cws_pkg::CWS_WAITING && (dresp || pend_d.timeout && !pend_q.timeout))
    begin
      wst_d = cws_pkg::CWS_RUN;
      case (srv_q)
        cws_pkg::CWS_SRC_TMO:  pend_d.timeout = 1'b0;
        cws_pkg::CWS_SRC_MOD:  srv_d = cws_pkg::CWS_SRC_NONE;
        cws_pkg::CWS_SRC_MARK: pend_d.mark = 1'b0;
        default:               srv_d = cws_pkg::CWS_SRC_NONE;
      endcase
      srv_d = cws_pkg::CWS_SRC_NONE;
    end
    if (x8_rise && mark_en_q)
      pend_d.mark = 1'b1;  // set wins over clear
    pend_d.modules = mreg_q;
    go_d  = (wst_d == cws_pkg::CWS_RUN);
    irq_d = pend_d.timeout | (|pend_d.modules) | pend_d.mark;
  end
  always_ff @(posedge clk)
  begin
    if (irst)
    begin
      st_q       <= 8'h00;
      mreg_q     <= 3'h0;
      wst_q      <= cws_pkg::CWS_RUN;
      go_q       <= 1'b1;
      tmo_q      <= 16'h0000;
      tmo_run_q  <= 1'b0;
      pend_q     <= '0;
      mark_en_q  <= 1'b0;
      srv_q      <= cws_pkg::CWS_SRC_NONE;
      vreq_q     <= 1'b0;
      mcyc_q     <= 1'b0;
      mark_ack_q <= 1'b0;
      vec_q      <= 8'h00;
      voe_q      <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      mreg_q     <= mreg_d;
      wst_q      <= wst_d;
      go_q       <= go_d;
      tmo_q      <= tmo_d;
      tmo_run_q  <= tmo_run_d;
      pend_q     <= pend_d;
      mark_en_q  <= mark_en_d;
      srv_q      <= srv_d;
      vreq_q     <= vreq_d;
      mcyc_q     <= mcyc_d;
      mark_ack_q <= mark_ack_d;
      vec_q      <= vec_d;
      voe_q      <= voe_d;
      irq_q      <= irq_d;
    end
  end
  // outputs straight from flip-flops
  assign processor_go         = go_q;
  assign processor_irq        = irq_q;
  assign system_reset         = sysrst_q;
  assign vector_out           = vec_q;
  assign vector_oe            = voe_q;
  assign status_word          = st_q;
  assign vector_request       = vreq_q;
  assign module_cycle_flag    = mcyc_q;
  assign delayed_response     = dly_ack;
  assign response_timeout_irq = pend_q.timeout;
  assign line_mark_irq        = pend_q.mark;
  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  sequence s_strobe_mod;
    stb_rise && addr15;
  endsequence
  property p_wait_on_module;
    @(posedge clk) disable iff (irst) s_strobe_mod |=> !processor_go;
  endproperty
  a_wait_on_module: assert property (p_wait_on_module) else $error("no wait on module cycle");
  property p_irq_or;
    @(posedge clk) disable iff (irst)
      (pend_q.timeout || pend_q.mark || |pend_q.modules) |-> ##[0:1] processor_irq;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("pending source without irq");
  property p_status_latch;
    @(posedge clk) disable iff (irst) stb_rise |=> status_word == $past(data_in);
  endproperty
  a_status_latch: assert property (p_status_latch) else $error("status not latched");
  property p_status_hold;
    @(posedge clk) disable iff (irst) !stb_rise |=> $stable(status_word);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed mid cycle");
  property p_mark_set;
    @(posedge clk) disable iff (irst) (x8_rise && mark_en_q) |=> line_mark_irq;
  endproperty
  a_mark_set: assert property (p_mark_set) else $error("line mark not raised");
  property p_mark_off;
    @(posedge clk) disable iff (irst) (!mark_en_q && !line_mark_irq) |=> !line_mark_irq;
  endproperty
  a_mark_off: assert property (p_mark_off) else $error("line mark while disabled");
  property p_dly;
    @(posedge clk) disable iff (irst) !ack_s |=> !delayed_response;
  endproperty
  a_dly: assert property (p_dly) else $error("delayed response without ack");
  property p_timeout_ends_wait;
    @(posedge clk) disable iff (irst) $rose(response_timeout_irq) |-> processor_go;
  endproperty
  a_timeout_ends_wait: assert property (p_timeout_ends_wait) else $error("timeout kept wait");
  property p_reset_hold;
    @(posedge clk) disable iff (rst) (settle_q < 4'h8) |-> system_reset;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");
endmodule

/* cws_module_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// plug-in module stand-in on the module bus
// ---------------------------------------------------------------
module cws_module_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // selection seen from the controller
  input  wire logic       cyc_sel,
  input  wire logic       vec_sel,
  // behaviour chosen by the bench
  input  wire logic       mute,
  input  wire logic [5:0] dly,
  input  wire logic [2:0] id,
  // module bus pins
  output logic            module_ack,
  output logic [2:0]      module_data_lines
);
  logic [5:0] cnt_q;

  // count from selection; answer once the chosen delay has passed
  always_ff @(posedge clk)
  begin
    if (rst || !(cyc_sel || vec_sel))
    begin
      cnt_q      <= 6'h00;
      module_ack <= 1'b0;
    end
    else
    begin
      if (cnt_q != 6'h3f)
        cnt_q <= cnt_q + 6'h01;
      module_ack <= !mute && (cnt_q >= dly);
    end
  end

  // id only valid under vector request; toggles otherwise so stale data matches only every other cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      module_data_lines <= 3'h0;
    else if (vec_sel)
      module_data_lines <= id;
    else
      module_data_lines <= ~module_data_lines;
  end
endmodule

/* cws_top_tb_top.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the processor support block
// ---------------------------------------------------------------
module cws_top_tb_top;
  localparam int LOSS = 2000;
  localparam int TMO  = 200;
  localparam int GAP  = 150;

  logic       clk, rst, line_pulse, line_times_eight, status_strobe, addr15;
  logic [7:0] data_in, status_word, vector_out;
  logic       mark_en_wr, mark_en_val, int_clear, module_ack, vector_oe;
  logic [2:0] module_irq, module_data_lines, id;
  logic       processor_go, processor_irq, system_reset, vector_request;
  logic       module_cycle_flag, delayed_response, response_timeout_irq, line_mark_irq;
  logic       mute, line_on;
  logic [5:0] dly;
  logic [7:0] d;
  int         num_errors, n_compared;

  cws_top #(.LOSS_CYC(LOSS), .TIMEOUT_CYC(TMO)) dut_u (
    .clk(clk), .rst(rst), .line_pulse(line_pulse), .line_times_eight(line_times_eight),
    .status_strobe(status_strobe), .addr15(addr15), .data_in(data_in),
    .mark_en_wr(mark_en_wr), .mark_en_val(mark_en_val), .int_clear(int_clear),
    .processor_go(processor_go), .processor_irq(processor_irq),
    .system_reset(system_reset), .vector_out(vector_out), .vector_oe(vector_oe),
    .status_word(status_word), .module_ack(module_ack), .module_irq(module_irq),
    .module_data_lines(module_data_lines), .vector_request(vector_request),
    .module_cycle_flag(module_cycle_flag), .delayed_response(delayed_response),
    .response_timeout_irq(response_timeout_irq), .line_mark_irq(line_mark_irq));

  cws_module_model mod_u (
    .clk(clk), .rst(rst), .cyc_sel(module_cycle_flag), .vec_sel(vector_request),
    .mute(mute), .dly(dly), .id(id), .module_ack(module_ack),
    .module_data_lines(module_data_lines));

  // clock: 50 ns period
  always #25 clk = ~clk;

  // line pulses keep coming while line_on is set
  initial forever
  begin
    repeat (GAP) @(posedge clk);
    line_pulse <= line_on;
    repeat (2) @(posedge clk);
    line_pulse <= 1'b0;
  end

  // expected vector for a module id; id 3 gives the base pattern
  function automatic logic [7:0] vec_of(input logic [2:0] mid);
    return {4'b1100, mid, 1'b1};
  endfunction

  // selects a design or module-model output for bounded waits
  function automatic logic sig(input int sel);
    case (sel)
      0:       return processor_go;
      1:       return module_ack;
      default: return response_timeout_irq;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait; a limit that runs out is a mismatch
  task automatic wait_hi(input int sel, input int lim);
    int k;
    k = 0;
    while (sig(sel) !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    chk("wait_done", {7'h00, sig(sel)}, 8'h01);
  endtask

  // one machine cycle start: status word and address bit on the strobe
  task automatic strobe(input logic a, input logic [7:0] w);
    @(posedge clk);
    addr15        <= a;
    data_in       <= w;
    status_strobe <= 1'b1;
    cyc(2);
    status_strobe <= 1'b0;
    cyc(6);
  endtask

  task automatic pulse_clear;
    int_clear <= 1'b1;
    cyc(1);
    int_clear <= 1'b0;
    cyc(3);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog sized well above the expected run length
  initial
  begin
    cyc(40000);
    num_errors++;
    results();
  end

  initial
  begin
    clk = 0; rst = 1; line_pulse = 0; line_times_eight = 0; status_strobe = 0;
    addr15 = 0; data_in = 8'h00; mark_en_wr = 0; mark_en_val = 0; int_clear = 0;
    module_irq = 3'h0; mute = 0; dly = 6'h00; id = 3'h1; line_on = 0;
    num_errors = 0; n_compared = 0;
    void'($urandom(32'haee3));
    cyc(12);
    rst <= 1'b0;
    line_on <= 1'b1;
    chk("go_after_rst", processor_go, 8'h01);
    // reset holds for eight line pulses, then lifts
    repeat (7) @(posedge line_pulse);
    cyc(20);
    chk("sysrst_7", system_reset, 8'h01);
    @(posedge line_pulse);
    cyc(20);
    chk("sysrst_8", system_reset, 8'h00);
    // missing line pulses re-enter reset
    line_on <= 1'b0;
    cyc(LOSS + 200);
    chk("sysrst_loss", system_reset, 8'h01);
    line_on <= 1'b1;
    repeat (10) @(posedge line_pulse);
    cyc(20);
    chk("sysrst_back", system_reset, 8'h00);
    // module cycles with random status and answer delay, zero delay first
    for (int i = 0; i < 3; i++)
    begin
      dly <= (i == 0) ? 6'h00 : 6'($urandom_range(1, 20));
      d = 8'($urandom) & 8'hfe;
      strobe(1'b1, d);
      chk("status", status_word, d);
      chk("mod_flag", module_cycle_flag, 8'h01);
      chk("go_wait", processor_go, 8'h00);
      wait_hi(1, 40);
      cyc(28);
      chk("dresp_early", delayed_response, 8'h00);
      chk("go_held", processor_go, 8'h00);
      wait_hi(0, 15);
      chk("dresp", delayed_response, 8'h01);
      strobe(1'b0, 8'h00);
      chk("go_plain", processor_go, 8'h01);
      chk("flag_off", module_cycle_flag, 8'h00);
      cyc(45);
    end
    // silent module: timeout ends the wait and interrupts
    mute <= 1'b1;
    strobe(1'b1, 8'h02);
    cyc(TMO - 30);
    chk("tmo_early", response_timeout_irq, 8'h00);
    wait_hi(2, 60);
    cyc(3);
    chk("go_tmo", processor_go, 8'h01);
    chk("irq_tmo", processor_irq, 8'h01);
    pulse_clear();
    chk("tmo_clr", response_timeout_irq, 8'h00);
    chk("irq_clr", processor_irq, 8'h00);
    // second timeout, then its acknowledge cycle answers itself and clears it
    strobe(1'b1, 8'h02);
    wait_hi(2, TMO + 20);
    strobe(1'b0, 8'h01);
    chk("go_tmo_ack", processor_go, 8'h01);
    chk("tmo_acked", response_timeout_irq, 8'h00);
    mute <= 1'b0;
    strobe(1'b0, 8'h00);
    // line mark armed, then a module request: module outranks mark
    mark_en_wr <= 1'b1;
    mark_en_val <= 1'b1;
    cyc(1);
    mark_en_wr <= 1'b0;
    line_times_eight <= 1'b1;
    cyc(3);
    line_times_eight <= 1'b0;
    cyc(6);
    chk("mark", line_mark_irq, 8'h01);
    chk("irq_mark", processor_irq, 8'h01);
    id = 3'h1 << $urandom_range(0, 2);
    module_irq <= id;
    strobe(1'b0, 8'h00);
    chk("irq_mod", processor_irq, 8'h01);
    strobe(1'b0, 8'h01);
    chk("go_int_ack_status", processor_go, 8'h00);
    chk("vreq", vector_request, 8'h01);
    wait_hi(0, 80);
    chk("vec_oe", vector_oe, 8'h01);
    chk("vec_mod", vector_out, vec_of(module_data_lines));
    chk("vec_id", vector_out, vec_of(id));
    module_irq <= 3'h0;
    strobe(1'b0, 8'h00);
    cyc(45);
    // mark acknowledge cycle gets its own response and clears
    strobe(1'b0, 8'h01);
    wait_hi(0, 80);
    chk("vec_mark", vector_out, vec_of(3'h3));
    chk("mark_done", line_mark_irq, 8'h00);
    strobe(1'b0, 8'h00);
    chk("irq_none", processor_irq, 8'h00);
    // disabled mark ignores the line clock
    mark_en_wr <= 1'b1;
    mark_en_val <= 1'b0;
    cyc(1);
    mark_en_wr <= 1'b0;
    line_times_eight <= 1'b1;
    cyc(3);
    line_times_eight <= 1'b0;
    cyc(6);
    chk("mark_off", line_mark_irq, 8'h00);
    results();
  end
endmodule
